// File: bench/lane_mon_props.sv
// Purpose: port-level checks of the lane monitor
// Assumes: one clock domain
// Notes: attached by bind below
`timescale 1ns/1ps
module lane_mon_props #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // register port
  input wire logic [lane_mon_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [lane_mon_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic [lane_mon_pkg::DATA_W-1:0] reg_rdata_o,
  // lane side
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] bad_disparity_err_i,
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] symbol_lock_i,
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] frame_lock_i,
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] config_sum_done_i,
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] config_sum_ok_i,
  // outputs watched
  input wire logic sync_request_o,
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] resync_start_o,
  input wire logic [2:0] sync_irq_o,
  input wire logic [lane_mon_pkg::NUM_ERR_TYPES*lane_mon_pkg::NUM_LANES*CNT_W-1:0] err_count_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence steady;
    ce_i && $past(ce_i) && $past(rstn_i);
  endsequence
  sequence frame_loss;
    steady ##0 (|($past(frame_lock_i) & ~frame_lock_i));
  endsequence
  sequence sym_loss;
    steady ##0 (|($past(symbol_lock_i) & ~symbol_lock_i));
  endsequence
  sequence rd_of(logic [11:0] a);
    steady ##0 (reg_rd_i && reg_addr_i == a);
  endsequence
  sequence wr7_of(logic [11:0] a);
    ce_i && reg_wr_i && reg_addr_i == a && reg_wdata_i[7];
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_SYNC_REQ: assert property (ce_i && !(&symbol_lock_i) |=> sync_request_o)
    else $error("sync request missing after lock loss");
  AST_RESYNC: assert property (frame_loss |=> |resync_start_o)
    else $error("no resync start after frame lock loss");
  AST_SYM_IRQ: assert property (sym_loss |=> sync_irq_o[0])
    else $error("symbol lock irq not set");
  AST_SYM_CLR: assert property (wr7_of(12'h470) ##0 &symbol_lock_i |=> !sync_irq_o[0])
    else $error("symbol lock irq not cleared");
  AST_FRAME_CLR: assert property (wr7_of(12'h471) ##0 &frame_lock_i |=> !sync_irq_o[1])
    else $error("frame lock irq not cleared");
  AST_SUM_BAD: assert property (ce_i && |(config_sum_done_i & ~config_sum_ok_i)
    |=> sync_irq_o[2])
    else $error("bad checksum irq not set");
  AST_SUM_CLR: assert property (wr7_of(12'h472) ##0 !(|(config_sum_done_i & ~config_sum_ok_i))
    |=> !sync_irq_o[2])
    else $error("checksum irq not cleared");
  AST_CNT_CLR: assert property (ce_i && reg_wr_i && reg_addr_i == 12'h46D && reg_wdata_i[5]
    && reg_wdata_i[2:0] == 3'h0 && !bad_disparity_err_i[0] |=> err_count_o[CNT_W-1:0] == '0)
    else $error("lane 0 disparity counter not zeroed");
  AST_SYM_RD: assert property (rd_of(12'h470) |=> reg_rdata_o == $past(symbol_lock_i, 2))
    else $error("symbol lock readback wrong");
  AST_FRAME_RD: assert property (rd_of(12'h471) |=> reg_rdata_o == $past(frame_lock_i, 2))
    else $error("frame lock readback wrong");
endmodule

bind serial_lane_error_sync_monitor lane_mon_props #(.CNT_W(CNT_W)) props (
  .sys_clk_i, .rstn_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
  .bad_disparity_err_i, .symbol_lock_i, .frame_lock_i, .config_sum_done_i, .config_sum_ok_i,
  .sync_request_o, .resync_start_o, .sync_irq_o, .err_count_o);

// File: bench/lane_tx_model.sv
// Purpose: behavioural transmitter at the far end of the lanes
// Assumes: lock state stands for what the lane receivers would report
// Notes: drop_i forces a lane to lose lock, bad_sum_i spoils the next checksum
`timescale 1ns/1ps
module lane_tx_model #(
  parameter int SYNC_LEN = 10,
  parameter int ILAS_LEN = 6
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // control from bench and receiver
  input wire logic sync_request_i,
  input wire logic [7:0] drop_i,
  input wire logic bad_sum_i,
  // lane state seen by receiver
  output logic [7:0] symbol_lock_o,
  output logic [7:0] frame_lock_o,
  output logic [7:0] sum_done_o,
  output logic [7:0] sum_ok_o
);
  int sync_q;
  int ilas_q;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_q <= 0;
      ilas_q <= 0;
      symbol_lock_o <= 8'h00;
      frame_lock_o <= 8'h00;
      sum_done_o <= 8'h00;
      sum_ok_o <= 8'h00;
    end else begin
      sum_done_o <= 8'h00;
      sync_q <= sync_request_i ? sync_q + 1 : 0;
      if (sync_request_i && sync_q == SYNC_LEN) begin
        symbol_lock_o <= 8'hFF;
      end
      // alignment only once every lane has symbol lock
      if (!sync_request_i && &symbol_lock_o && frame_lock_o != 8'hFF) begin
        ilas_q <= ilas_q + 1;
        if (ilas_q == ILAS_LEN) begin
          ilas_q <= 0;
          frame_lock_o <= 8'hFF;
          sum_done_o <= 8'hFF;
          sum_ok_o <= bad_sum_i ? 8'h00 : 8'hFF;
        end
      end
      // a lost lane wins over any gain
      if (|drop_i) begin
        symbol_lock_o <= symbol_lock_o & ~drop_i;
        frame_lock_o <= frame_lock_o & ~drop_i;
      end
    end
  end
endmodule

// File: bench/serial_lane_error_sync_monitor_tb.sv
// Purpose: self-checking bench of the lane error and sync monitor
// Assumes: ce_i high, error threshold fixed at three
// Notes: lane lock traffic comes from the transmitter model
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); end end
module serial_lane_error_sync_monitor_tb;
  localparam int CW = 8;
  logic sys_clk_i = 1'b0;
  logic rstn_i;
  logic [11:0] reg_addr_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic [2:0][7:0] err_q;
  logic [7:0] symbol_lock_i;
  logic [7:0] frame_lock_i;
  logic [7:0] sum_done;
  logic [7:0] sum_ok;
  logic sync_request_o;
  logic [2:0] err_irq_o;
  logic [2:0] sync_irq_o;
  logic [3*8*CW-1:0] err_count_o;
  logic [7:0] drop;
  logic bad_sum;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [11:0] offs;

  always #5 sys_clk_i = ~sys_clk_i;

  serial_lane_error_sync_monitor #(.CNT_W(CW)) dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .bad_disparity_err_i(err_q[0]), .table_miss_err_i(err_q[1]),
    .stray_control_err_i(err_q[2]), .error_threshold_i(8'h03), .symbol_lock_i(symbol_lock_i),
    .frame_lock_i(frame_lock_i), .config_sum_done_i(sum_done), .config_sum_ok_i(sum_ok),
    .sync_request_o(sync_request_o), .resync_start_o(), .err_irq_o(err_irq_o),
    .sync_irq_o(sync_irq_o), .err_count_o(err_count_o));

  lane_tx_model tx (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sync_request_i(sync_request_o), .drop_i(drop),
    .bad_sum_i(bad_sum), .symbol_lock_o(symbol_lock_i), .frame_lock_o(frame_lock_i),
    .sum_done_o(sum_done), .sum_ok_o(sum_ok));

  // ----------------------------------------
  // register port and lane tasks
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    `CHK(reg_rdata_o, e)
  endtask

  task automatic pulse(input int t, input int ln, input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      err_q <= 24'(1 << (t * 8 + ln));
      @(posedge sys_clk_i);
      err_q <= '0;
    end
    repeat (3) @(posedge sys_clk_i);
  endtask

  task automatic lose_and_relock(input int ln);
    @(posedge sys_clk_i);
    drop <= 8'(1 << ln);
    @(posedge sys_clk_i);
    drop <= 8'h00;
    // let the drop reach the lanes, else the old lock ends the wait at once
    @(posedge sys_clk_i);
    for (int i = 0; i < 200 && !(frame_lock_i == 8'hFF && sync_request_o === 1'b0); i++) begin
      @(posedge sys_clk_i);
    end
    repeat (3) @(posedge sys_clk_i);
    `CHK(frame_lock_i, 8'hFF)
  endtask

  task automatic final_report();
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn_i = 1'b0;
    reg_addr_i = 12'h000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wdata_i = 8'h00;
    err_q = '0;
    drop = 8'h00;
    bad_sum = 1'b0;
    repeat (16) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK(sync_request_o, 1'b1)
    rd(12'h46D, 8'h00);
    rd(12'h400, 8'h00);
    lose_and_relock(0);
    rd(12'h470, 8'hFF);
    rd(12'h472, 8'hFF);
    for (int t = 0; t < 3; t++) begin
      offs = 12'h46D + 12'(t);
      pulse(t, t, 3);
      rd(offs, 8'(1 << t));
      `CHK(err_irq_o[t], 1'b1)
      wr(offs, 8'(8'hA0 | (t ^ 1)));
      `CHK(err_count_o[(t*8+t)*CW +: CW], 8'h03)
      wr(offs, 8'(8'h98 | t));
      repeat (2) @(posedge sys_clk_i);
      `CHK(err_irq_o[t], 1'b0)
      `CHK(err_count_o[(t*8+t)*CW +: CW], 8'h03)
      wr(offs, 8'(8'h20 | t));
      `CHK(err_count_o[(t*8+t)*CW +: CW], 8'h00)
      rd(offs, 8'h00);
      wr(offs, 8'(8'h40 | t));
      pulse(t, t, 2);
      `CHK(err_count_o[(t*8+t)*CW +: CW], 8'h00)
    end
    @(posedge sys_clk_i);
    drop <= 8'h04;
    @(posedge sys_clk_i);
    drop <= 8'h00;
    rd(12'h470, 8'hFB);
    rd(12'h471, 8'hFB);
    `CHK(sync_request_o, 1'b1)
    lose_and_relock(2);
    `CHK(sync_irq_o[1:0], 2'b11)
    wr(12'h470, 8'h80);
    `CHK(sync_irq_o[1:0], 2'b10)
    wr(12'h471, 8'h80);
    `CHK(sync_irq_o[1], 1'b0)
    bad_sum <= 1'b1;
    lose_and_relock(5);
    `CHK(sync_irq_o[2], 1'b1)
    rd(12'h472, 8'h00);
    wr(12'h472, 8'h80);
    `CHK(sync_irq_o[2], 1'b0)
    bad_sum <= 1'b0;
    lose_and_relock(7);
    rd(12'h472, 8'hFF);
    final_report();
  end
endmodule

// File: verilog/lane_err_counter.sv
// Purpose: one lane's error counter with threshold flag and interrupt
// Assumes: error strobe is one cycle per error event
// Notes: counter saturates instead of wrapping
`timescale 1ns/1ps
module lane_err_counter #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // error event and software actions
  input wire logic err_i,
  input wire logic count_off_i,
  input wire logic count_clear_i,
  input wire logic irq_clear_i,
  input wire logic [CNT_W-1:0] threshold_i,
  // status
  output logic [CNT_W-1:0] count_o,
  output logic reached_o,
  output logic irq_o
);

  logic [CNT_W-1:0] count_q;
  logic off_q;
  logic reached_q;
  logic irq_q;
  logic reached_d;

  // off stays until device reset, so a stray write cannot re-arm it
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      off_q <= 1'b0;
    end else if (ce_i && count_off_i) begin
      off_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_q <= '0;
    end else if (ce_i) begin
      if (count_clear_i) begin
        count_q <= '0;
      end else if (err_i && !off_q && (count_q != {CNT_W{1'b1}})) begin
        count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign reached_d = (count_q >= threshold_i);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reached_q <= 1'b0;
    end else if (ce_i) begin
      reached_q <= reached_d;
    end
  end

  // set on reaching threshold wins over a same-cycle clear
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      if (reached_d && !reached_q) begin
        irq_q <= 1'b1;
      end else if (irq_clear_i) begin
        irq_q <= 1'b0;
      end
    end
  end

  assign count_o = count_q;
  assign reached_o = reached_q;
  assign irq_o = irq_q;

endmodule

// File: verilog/lane_mon_pkg.sv
// Purpose: shared constants of the lane error and sync monitor
// Assumes: eight lanes, byte-wide register port
// Notes: offsets are byte addresses on the register port
package lane_mon_pkg;

  localparam int NUM_LANES = 8;
  localparam int NUM_ERR_TYPES = 3;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int LANE_SEL_W = 3;

  // -------------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------------
  localparam logic [11:0] BAD_DISPARITY_OFFS = 12'h46D;
  localparam logic [11:0] TABLE_MISS_OFFS = 12'h46E;
  localparam logic [11:0] STRAY_CONTROL_OFFS = 12'h46F;
  localparam logic [11:0] SYMBOL_LOCK_OFFS = 12'h470;
  localparam logic [11:0] FRAME_LOCK_OFFS = 12'h471;
  localparam logic [11:0] CONFIG_SUM_OFFS = 12'h472;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int IRQ_CLEAR_BIT = 7;
  localparam int COUNTER_OFF_BIT = 6;
  localparam int COUNTER_CLEAR_BIT = 5;
  localparam int LANE_SEL_LSB = 0;

  // error type indices
  localparam int ERR_BAD_DISPARITY = 0;
  localparam int ERR_TABLE_MISS = 1;
  localparam int ERR_STRAY_CONTROL = 2;

  // interrupt vector positions
  localparam int IRQ_SYMBOL_LOCK_BIT = 0;
  localparam int IRQ_FRAME_LOCK_BIT = 1;
  localparam int IRQ_CONFIG_SUM_BIT = 2;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

// File: verilog/serial_lane_error_sync_monitor.sv
// Purpose: per-lane error counters and sync status of a multi-lane receiver
// Assumes: lane status and error inputs are synchronous to sys_clk_i
// Notes: byte-wide register port, read data one cycle after the read strobe
//
// What the document asks of this block
// RULE1: a one in bit 7 of the bad-disparity control clears that interrupt for the chosen lane.
// RULE2: a one in bit 6 of the bad-disparity control stops the chosen lane's counter.
// RULE3: a one in bit 5 of the bad-disparity control zeroes the chosen lane's counter.
// RULE4: bits [2:0] of each error control write pick the lane for bits [7:5]; [4:3] read zero. Reads here return lane 3 and 4 flags in [4:3].
// RULE5: the table-miss status has one bit per lane, set when its count reaches threshold.
// RULE6: the table-miss and stray-control controls work exactly like the bad-disparity one.
// RULE7: the stray-control status has one bit per lane, set when its count reaches threshold.
// RULE8: the symbol lock register reads 1 per lane that has code group sync, 0 if lost.
// RULE9: a one in bit 7 of the symbol lock register clears its interrupt, vector bit 0.
// RULE10: any lane losing code group sync raises the sync request to the transmitter.
// RULE11: the frame lock register shows the live per-lane frame sync state.
// RULE12: a lane losing frame sync starts a new sync sequence on its own.
// RULE13: a one in bit 7 of the frame lock register clears the frame sync interrupt.
// RULE14: the config sum register reads 1 per lane whose last checksum matched, else 0.
// RULE15: a one in bit 7 of the config sum register clears its interrupt, vector bit 2.
// RULE16: the bad-disparity status has one bit per lane, set when its count reaches threshold.
// RULE17: the transmitter answers the sync request with sync characters, then lane alignment.
`timescale 1ns/1ps
module serial_lane_error_sync_monitor #(
  parameter int CNT_W = 8
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // register port
  input wire logic [lane_mon_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [lane_mon_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [lane_mon_pkg::DATA_W-1:0] reg_rdata_o,
  // error events per lane
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] bad_disparity_err_i,
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] table_miss_err_i,
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] stray_control_err_i,
  input wire logic [CNT_W-1:0] error_threshold_i,
  // lane sync status
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] symbol_lock_i,
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] frame_lock_i,
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] config_sum_done_i,
  input wire logic [lane_mon_pkg::NUM_LANES-1:0] config_sum_ok_i,
  // link side
  output logic sync_request_o,
  output logic [lane_mon_pkg::NUM_LANES-1:0] resync_start_o,
  // interrupt and counter status
  output logic [lane_mon_pkg::NUM_ERR_TYPES-1:0] err_irq_o,
  output logic [2:0] sync_irq_o,
  output logic [lane_mon_pkg::NUM_ERR_TYPES*lane_mon_pkg::NUM_LANES*CNT_W-1:0] err_count_o
);

  localparam int L = lane_mon_pkg::NUM_LANES;
  localparam int T = lane_mon_pkg::NUM_ERR_TYPES;

  logic [L-1:0] err_in [T];
  logic [L-1:0] reached [T];
  logic [L-1:0] lane_irq [T];
  logic [T-1:0] ctrl_wr;
  logic [L-1:0] lane_hit;
  logic [L-1:0] symbol_lock_q;
  logic [L-1:0] frame_lock_q;
  logic [L-1:0] config_sum_q;
  logic [L-1:0] resync_q;
  logic sync_request_q;
  logic symbol_irq_q;
  logic frame_irq_q;
  logic sum_irq_q;
  logic [lane_mon_pkg::DATA_W-1:0] rdata_q;
  logic [lane_mon_pkg::DATA_W-1:0] rdata_d;
  logic symbol_lost;
  logic frame_lost;
  logic sum_bad;
  logic symbol_irq_clr;
  logic frame_irq_clr;
  logic sum_irq_clr;
  logic hit_symbol;
  logic hit_frame;
  logic hit_sum;
  logic wr_irq_clear;
  logic wr_counter_off;
  logic wr_counter_clear;
  logic [lane_mon_pkg::LANE_SEL_W-1:0] wr_lane_sel;
  logic [L-1:0] bad_disparity_lane_flags;
  logic [L-1:0] table_miss_lane_flags;
  logic [L-1:0] stray_control_lane_flags;

  assign err_in[lane_mon_pkg::ERR_BAD_DISPARITY] = bad_disparity_err_i;
  assign err_in[lane_mon_pkg::ERR_TABLE_MISS] = table_miss_err_i;
  assign err_in[lane_mon_pkg::ERR_STRAY_CONTROL] = stray_control_err_i;

  // -------------------------------------------------------------------------
  // write data fields
  // -------------------------------------------------------------------------
  // one field layout shared by all three error controls
  // bits [4:3] are reserved, so nothing below looks at them
  assign wr_irq_clear = reg_wdata_i[lane_mon_pkg::IRQ_CLEAR_BIT];
  assign wr_counter_off = reg_wdata_i[lane_mon_pkg::COUNTER_OFF_BIT];
  assign wr_counter_clear = reg_wdata_i[lane_mon_pkg::COUNTER_CLEAR_BIT];
  assign wr_lane_sel = reg_wdata_i[lane_mon_pkg::LANE_SEL_LSB +: lane_mon_pkg::LANE_SEL_W];

  // -------------------------------------------------------------------------
  // error control write decode
  // -------------------------------------------------------------------------
  // RULE6: three alike controls
  assign ctrl_wr[lane_mon_pkg::ERR_BAD_DISPARITY] =
    reg_wr_i && (reg_addr_i == lane_mon_pkg::BAD_DISPARITY_OFFS);
  assign ctrl_wr[lane_mon_pkg::ERR_TABLE_MISS] =
    reg_wr_i && (reg_addr_i == lane_mon_pkg::TABLE_MISS_OFFS);
  assign ctrl_wr[lane_mon_pkg::ERR_STRAY_CONTROL] =
    reg_wr_i && (reg_addr_i == lane_mon_pkg::STRAY_CONTROL_OFFS);

  // -------------------------------------------------------------------------
  // per-lane counters
  // -------------------------------------------------------------------------
  genvar gt;
  genvar gl;
  generate
    for (gl = 0; gl < L; gl++) begin : g_hit
      // int copy of the loop index, so it can be cut to the field width
      localparam int LANE_NUM = gl;
      // RULE4: lane field picks target
      assign lane_hit[gl] =
        (wr_lane_sel == LANE_NUM[lane_mon_pkg::LANE_SEL_W-1:0]);
    end
    for (gt = 0; gt < T; gt++) begin : g_type
      for (gl = 0; gl < L; gl++) begin : g_lane
        logic sel;
        assign sel = ctrl_wr[gt] && lane_hit[gl];
        lane_err_counter #(
          .CNT_W(CNT_W)
        ) u_cnt (
          .sys_clk_i(sys_clk_i),
          .rstn_i(rstn_i),
          .ce_i(ce_i),
          .err_i(err_in[gt][gl]),
          // RULE2: bit 6 stops counter
          .count_off_i(sel && wr_counter_off),
          // RULE3: bit 5 zeroes counter
          .count_clear_i(sel && wr_counter_clear),
          // RULE1: bit 7 clears lane irq
          .irq_clear_i(sel && wr_irq_clear),
          .threshold_i(error_threshold_i),
          .count_o(err_count_o[(gt*L+gl)*CNT_W +: CNT_W]),
          .reached_o(reached[gt][gl]),
          .irq_o(lane_irq[gt][gl])
        );
      end
      assign err_irq_o[gt] = |lane_irq[gt];
    end
  endgenerate

  // -------------------------------------------------------------------------
  // error status flags
  // -------------------------------------------------------------------------
  // flags lag the count by one cycle, the compare is registered
  assign bad_disparity_lane_flags = reached[lane_mon_pkg::ERR_BAD_DISPARITY];
  assign table_miss_lane_flags = reached[lane_mon_pkg::ERR_TABLE_MISS];
  assign stray_control_lane_flags = reached[lane_mon_pkg::ERR_STRAY_CONTROL];

  // -------------------------------------------------------------------------
  // sync status capture
  // -------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      symbol_lock_q <= lane_mon_pkg::FLAGS_RESET;
      frame_lock_q <= lane_mon_pkg::FLAGS_RESET;
    end else if (ce_i) begin
      // RULE8: live symbol lock
      symbol_lock_q <= symbol_lock_i;
      // RULE11: live frame lock
      frame_lock_q <= frame_lock_i;
    end
  end

  // RULE14: latch result of last checksum per lane
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      config_sum_q <= lane_mon_pkg::FLAGS_RESET;
    end else if (ce_i) begin
      config_sum_q <= (config_sum_done_i & config_sum_ok_i) |
                      (~config_sum_done_i & config_sum_q);
    end
  end

  // loss is an edge, so a lane still down does not re-raise a cleared irq
  assign symbol_lost = |(symbol_lock_q & ~symbol_lock_i);
  assign frame_lost = |(frame_lock_q & ~frame_lock_i);
  assign sum_bad = |(config_sum_done_i & ~config_sum_ok_i);

  // -------------------------------------------------------------------------
  // link side outputs
  // -------------------------------------------------------------------------
  // RULE10: any lane without lock requests sync
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_request_q <= 1'b0;
    end else if (ce_i) begin
      sync_request_q <= ~&symbol_lock_i;
    end
  end

  // RULE12: frame loss starts resync
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      resync_q <= lane_mon_pkg::FLAGS_RESET;
    end else if (ce_i) begin
      resync_q <= frame_lock_q & ~frame_lock_i;
    end
  end

  assign sync_request_o = sync_request_q;
  assign resync_start_o = resync_q;

  // -------------------------------------------------------------------------
  // sync interrupts, set wins over clear
  // -------------------------------------------------------------------------
  // flag bits of these registers are status, only bit 7 acts on a write
  assign hit_symbol = reg_wr_i && (reg_addr_i == lane_mon_pkg::SYMBOL_LOCK_OFFS);
  assign hit_frame = reg_wr_i && (reg_addr_i == lane_mon_pkg::FRAME_LOCK_OFFS);
  assign hit_sum = reg_wr_i && (reg_addr_i == lane_mon_pkg::CONFIG_SUM_OFFS);
  assign symbol_irq_clr = hit_symbol && wr_irq_clear;
  assign frame_irq_clr = hit_frame && wr_irq_clear;
  assign sum_irq_clr = hit_sum && wr_irq_clear;

  // RULE9: symbol lock irq clear
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      symbol_irq_q <= 1'b0;
    end else if (ce_i) begin
      if (symbol_lost) begin
        symbol_irq_q <= 1'b1;
      end else if (symbol_irq_clr) begin
        symbol_irq_q <= 1'b0;
      end
    end
  end

  // RULE13: frame lock irq clear
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_irq_q <= 1'b0;
    end else if (ce_i) begin
      if (frame_lost) begin
        frame_irq_q <= 1'b1;
      end else if (frame_irq_clr) begin
        frame_irq_q <= 1'b0;
      end
    end
  end

  // RULE15: checksum irq clear
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sum_irq_q <= 1'b0;
    end else if (ce_i) begin
      if (sum_bad) begin
        sum_irq_q <= 1'b1;
      end else if (sum_irq_clr) begin
        sum_irq_q <= 1'b0;
      end
    end
  end

  always_comb begin
    sync_irq_o = 3'h0;
    sync_irq_o[lane_mon_pkg::IRQ_SYMBOL_LOCK_BIT] = symbol_irq_q;
    sync_irq_o[lane_mon_pkg::IRQ_FRAME_LOCK_BIT] = frame_irq_q;
    sync_irq_o[lane_mon_pkg::IRQ_CONFIG_SUM_BIT] = sum_irq_q;
  end

  // -------------------------------------------------------------------------
  // readback
  // -------------------------------------------------------------------------
  always_comb begin
    case (reg_addr_i)
      // RULE16: bad disparity lane flags
      lane_mon_pkg::BAD_DISPARITY_OFFS: rdata_d = bad_disparity_lane_flags;
      // RULE5: table miss lane flags
      lane_mon_pkg::TABLE_MISS_OFFS: rdata_d = table_miss_lane_flags;
      // RULE7: stray control lane flags
      lane_mon_pkg::STRAY_CONTROL_OFFS: rdata_d = stray_control_lane_flags;
      lane_mon_pkg::SYMBOL_LOCK_OFFS: rdata_d = symbol_lock_q;
      lane_mon_pkg::FRAME_LOCK_OFFS: rdata_d = frame_lock_q;
      lane_mon_pkg::CONFIG_SUM_OFFS: rdata_d = config_sum_q;
      default: rdata_d = lane_mon_pkg::UNMAPPED_READ;
    endcase
  end

  // read data holds until the next read strobe
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= lane_mon_pkg::RDATA_RESET;
    end else if (ce_i && reg_rd_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule
